/* core/quota_port_unit.sv */
// One port's charge accumulator, threshold check and response holder.
// Assumes a one-cycle update pulse and a charge increment valid with it.
`timescale 1ns/1ps
`default_nettype none
module quota_port_unit
	import quota_regs_pkg::*;
#(
	parameter int unsigned DELTA_W = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Control
	input wire logic update_i,
	input wire logic [DELTA_W-1:0] delta_i,
	input wire logic enable_i,
	input wire logic clear_i,
	input wire logic [LIMIT_W-1:0] limit_i,
	input wire logic [1:0] response_i,
	input wire logic other_alert_i,
	// Results
	output logic [CHARGE_W-1:0] total_o,
	output quota_status_t status_o
);

	quota_state_t s_reg;
	quota_state_t s_next;
	logic [CHARGE_W:0] sum;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		sum = {1'b0, s_reg.total} + (CHARGE_W + 1)'(delta_i);
		if (!enable_i || clear_i) begin
			s_next.total = '0;
			s_next.status.hit_flag = 1'b0;
			s_next.status.reported = 1'b0;
			s_next.status.disconnect = 1'b0;
			s_next.status.sleep_req = 1'b0;
		end else if (update_i) begin
			// Saturate rather than wrap, so a full total never looks small again.
			s_next.total = sum[CHARGE_W] ? '1 : sum[CHARGE_W-1:0];
			if (s_next.total[CHARGE_W-1:LIMIT_SHIFT] >= limit_i) begin
				s_next.status.hit_flag = 1'b1;
				unique case (response_i)
					RESP_REPORT: begin
						s_next.status.reported = 1'b1;
					end
					RESP_DISCONNECT: begin
						s_next.status.reported = 1'b1;
						s_next.status.disconnect = 1'b1;
					end
					RESP_SLEEP: begin
						s_next.status.disconnect = 1'b1;
						s_next.status.sleep_req = 1'b1;
					end
					RESP_IGNORE: begin
						s_next.status.reported = s_reg.status.reported;
					end
				endcase
			end
		end
		// Alert is released only when no other cause holds it.
		s_next.status.alert_n = ~(s_next.status.reported | other_alert_i);
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '{total: '0, status: '{hit_flag: 1'b0, reported: 1'b0,
				disconnect: 1'b0, sleep_req: 1'b0, alert_n: 1'b1}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign total_o = s_reg.total;
	assign status_o = s_reg.status;

endmodule
`default_nettype wire

/* core/quota_reg_bank.sv */
// Charge quota and port 2 limit behaviour register bank with its two port units.
// Assumes a byte register port driven by the SMBus engine, one access per cycle.
`timescale 1ns/1ps
`default_nettype none
module quota_reg_bank
	import quota_regs_pkg::*;
#(
	parameter int unsigned DELTA_W = 16,
	parameter int unsigned UPDATE_COUNT = UPDATE_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Byte register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic reg_rd_start_i,
	output logic [7:0] reg_rdata_o,
	// Power state and measurement
	input wire logic active_i,
	input wire logic sleep_i,
	input wire logic [DELTA_W-1:0] charge_delta_p1_i,
	input wire logic [DELTA_W-1:0] charge_delta_p2_i,
	input wire logic other_alert_p1_i,
	input wire logic other_alert_p2_i,
	input wire logic auto_drain_enable_i,
	// Port responses
	output quota_status_t quota_status_p1_o,
	output quota_status_t quota_status_p2_o,
	// Port 2 limit behaviour
	output logic manual_drain_load_p2_o,
	output logic [1:0] min_bus_volt_sel_p2_o,
	output logic [2:0] min_bus_current_sel_p2_o
);

	bank_state_t s_reg;
	bank_state_t s_next;
	logic [CHARGE_W-1:0] total_p1;
	logic [CHARGE_W-1:0] total_p2;
	logic [31:0] snap_word;

	// ---------------------------------------------------------------
	// Port units
	// ---------------------------------------------------------------
	quota_port_unit #(
		.DELTA_W(DELTA_W)
	) u_port1 (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.update_i(s_reg.tick),
		.delta_i(charge_delta_p1_i),
		.enable_i(s_reg.cfg.enable_p1),
		.clear_i(s_reg.cfg.clear_p1),
		.limit_i(s_reg.limit_p1),
		.response_i(s_reg.cfg.response_p1),
		.other_alert_i(other_alert_p1_i),
		.total_o(total_p1),
		.status_o(quota_status_p1_o)
	);

	// The port 2 total is kept but not mapped in this bank.
	quota_port_unit #(
		.DELTA_W(DELTA_W)
	) u_port2 (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.update_i(s_reg.tick),
		.delta_i(charge_delta_p2_i),
		.enable_i(s_reg.cfg.enable_p2),
		.clear_i(s_reg.cfg.clear_p2),
		.limit_i(s_reg.limit_p2),
		.response_i(s_reg.cfg.response_p2),
		.other_alert_i(other_alert_p2_i),
		.total_o(total_p2),
		.status_o(quota_status_p2_o)
	);

	// Port 2 total has no readout here; fold it away explicitly.
	logic unused_total_p2;
	assign unused_total_p2 = ^total_p2;

	assign snap_word = {s_reg.snap, {TOTAL_PAD{1'b0}}};

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		// The update timer only runs in the active power state.
		if (active_i) begin
			if (s_reg.tick_cnt >= TICK_W'(UPDATE_COUNT - 1)) begin
				s_next.tick_cnt = '0;
				s_next.tick = 1'b1;
			end else begin
				s_next.tick_cnt = s_reg.tick_cnt + TICK_W'(1);
			end
		end
		// A read that begins at any byte freezes the whole total.
		if (reg_rd_start_i) begin
			s_next.snap = total_p1;
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_TOTAL_P1: s_next.rdata = snap_word[31:24];
				ADDR_TOTAL_P1 + 8'h01: s_next.rdata = snap_word[23:16];
				ADDR_TOTAL_P1 + 8'h02: s_next.rdata = snap_word[15:8];
				ADDR_TOTAL_P1 + 8'h03: s_next.rdata = snap_word[7:0];
				ADDR_LIMIT_P2: s_next.rdata = s_reg.limit_p2[15:8];
				ADDR_LIMIT_P2 + 8'h01: s_next.rdata = s_reg.limit_p2[7:0];
				ADDR_LIMIT_P1: s_next.rdata = s_reg.limit_p1[15:8];
				ADDR_LIMIT_P1 + 8'h01: s_next.rdata = s_reg.limit_p1[7:0];
				ADDR_QUOTA_CFG: s_next.rdata = s_reg.cfg;
				ADDR_LIMIT_BEH_P2: s_next.rdata = s_reg.beh;
				default: s_next.rdata = 8'h00;
			endcase
		end
		// The total bytes are read-only; writes there are dropped.
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_LIMIT_P2: s_next.limit_p2[15:8] = reg_wdata_i;
				ADDR_LIMIT_P2 + 8'h01: s_next.limit_p2[7:0] = reg_wdata_i;
				ADDR_LIMIT_P1: s_next.limit_p1[15:8] = reg_wdata_i;
				ADDR_LIMIT_P1 + 8'h01: s_next.limit_p1[7:0] = reg_wdata_i;
				ADDR_QUOTA_CFG: s_next.cfg = reg_wdata_i;
				ADDR_LIMIT_BEH_P2: s_next.beh = reg_wdata_i;
				default: s_next.cfg = s_next.cfg;
			endcase
		end
		// Sleep loses the behaviour register, so it wakes at reset values.
		if (sleep_i) begin
			s_next.beh = RST_LIMIT_BEH;
		end
		// The drain load never turns the switch off; it only adds a load.
		s_next.drain = s_next.beh.drain & ~auto_drain_enable_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_reg <= '{tick_cnt: '0, tick: 1'b0, cfg: RST_QUOTA_CFG, limit_p1: RST_LIMIT,
				limit_p2: RST_LIMIT, beh: RST_LIMIT_BEH, snap: '0, rdata: 8'h00, drain: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o = s_reg.rdata;
	assign manual_drain_load_p2_o = s_reg.drain;
	assign min_bus_volt_sel_p2_o = s_reg.beh.volt_sel;
	assign min_bus_current_sel_p2_o = s_reg.beh.current_sel;

endmodule
`default_nettype wire

/* include/quota_regs_pkg.sv */
// Constants, field layouts and carrier types for the charge quota register bank.
// Assumes byte-wide register access by an SMBus-style command engine outside.
package quota_regs_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_TOTAL_P1 = 8'h1A;
	localparam logic [7:0] ADDR_LIMIT_P2 = 8'h1E;
	localparam logic [7:0] ADDR_LIMIT_P1 = 8'h20;
	localparam logic [7:0] ADDR_QUOTA_CFG = 8'h22;
	localparam logic [7:0] ADDR_LIMIT_BEH_P2 = 8'h23;

	localparam logic [15:0] RST_LIMIT = 16'hFFFF;
	localparam logic [7:0] RST_QUOTA_CFG = 8'h11;
	localparam logic [7:0] RST_LIMIT_BEH = 8'h96;

	// ---------------------------------------------------------------
	// Widths and codes
	// ---------------------------------------------------------------
	localparam int unsigned CHARGE_W = 26;
	localparam int unsigned LIMIT_W = 16;
	localparam int unsigned LIMIT_SHIFT = 10;
	localparam int unsigned TOTAL_PAD = 6;
	localparam logic [1:0] RESP_REPORT = 2'h0;
	localparam logic [1:0] RESP_DISCONNECT = 2'h1;
	localparam logic [1:0] RESP_SLEEP = 2'h2;
	localparam logic [1:0] RESP_IGNORE = 2'h3;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned UPDATE_PERIOD_MS = 1000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned UPDATE_CYCLES = UPDATE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned TICK_W = 26;

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic enable_p1;
		logic clear_p1;
		logic [1:0] response_p1;
		logic enable_p2;
		logic clear_p2;
		logic [1:0] response_p2;
	} quota_cfg_t;

	typedef struct packed {
		logic [1:0] volt_sel;
		logic drain;
		logic [2:0] current_sel;
		logic [1:0] reserved;
	} limit_beh_t;

	typedef struct packed {
		logic hit_flag;
		logic reported;
		logic disconnect;
		logic sleep_req;
		logic alert_n;
	} quota_status_t;

	typedef struct packed {
		logic [CHARGE_W-1:0] total;
		quota_status_t status;
	} quota_state_t;

	typedef struct packed {
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		quota_cfg_t cfg;
		logic [LIMIT_W-1:0] limit_p1;
		logic [LIMIT_W-1:0] limit_p2;
		limit_beh_t beh;
		logic [CHARGE_W-1:0] snap;
		logic [7:0] rdata;
		logic drain;
	} bank_state_t;

endpackage

/* testbench/quota_reg_bank_asserts.sv */
// Port checker for the quota register bank.
// Assumes it is bound to the top module from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module quota_reg_bank_asserts
	import quota_regs_pkg::*;
(
	// Clock, reset and register port
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Port side
	input wire logic sleep_i,
	input wire logic auto_drain_enable_i,
	input wire logic other_alert_p1_i,
	input wire quota_status_t quota_status_p1_o,
	input wire logic manual_drain_load_p2_o,
	input wire logic [1:0] min_bus_volt_sel_p2_o,
	input wire logic [2:0] min_bus_current_sel_p2_o
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	wire logic cfg_wr = reg_wr_i && reg_addr_i == ADDR_QUOTA_CFG;
	wire logic beh_wr = reg_wr_i && reg_addr_i == ADDR_LIMIT_BEH_P2 && !sleep_i;
	// Local variables live in named properties; the written byte is kept for three cycles.
	property p_volt_follows;
		logic [7:0] d;
		(beh_wr, d = reg_wdata_i) |-> ##3 (sleep_i || min_bus_volt_sel_p2_o == d[7:6]);
	endproperty
	property p_current_follows;
		logic [7:0] d;
		(beh_wr, d = reg_wdata_i) |-> ##3 (sleep_i || min_bus_current_sel_p2_o == d[4:2]);
	endproperty
	property p_drain_follows;
		logic [7:0] d;
		(beh_wr, d = reg_wdata_i) |-> ##3
			(sleep_i || manual_drain_load_p2_o == (d[5] && !auto_drain_enable_i));
	endproperty
	chk_pad_zero: assert property (reg_rd_i && reg_addr_i == 8'h1D |=> reg_rdata_o[5:0] == 6'h00)
		else $error("charge total pad bits not zero");
	chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h40 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_disable_clears: assert property (cfg_wr && !reg_wdata_i[7] |-> ##3 !quota_status_p1_o.hit_flag && !quota_status_p1_o.disconnect)
		else $error("disable left response applied");
	chk_clear_release: assert property (cfg_wr && reg_wdata_i[6] |-> ##3 !quota_status_p1_o.hit_flag && (quota_status_p1_o.alert_n || other_alert_p1_i))
		else $error("clear did not release");
	chk_sleep_defaults: assert property (sleep_i [*2] |-> min_bus_volt_sel_p2_o == 2'h2 && min_bus_current_sel_p2_o == 3'h5 && !manual_drain_load_p2_o)
		else $error("behaviour kept through sleep");
	chk_auto_mask: assert property (auto_drain_enable_i [*2] |-> !manual_drain_load_p2_o)
		else $error("drain load under automatic drain");
	chk_volt_follows: assert property (p_volt_follows)
		else $error("voltage select wrong");
	chk_current_follows: assert property (p_current_follows)
		else $error("current select wrong");
	chk_drain_follows: assert property (p_drain_follows)
		else $error("drain load wrong");
	chk_sleep_resp: assert property (quota_status_p1_o.sleep_req |-> quota_status_p1_o.disconnect && quota_status_p1_o.hit_flag)
		else $error("sleep response without disconnect");
	cover property ($rose(quota_status_p1_o.hit_flag));
	cover property ($rose(manual_drain_load_p2_o));
	cover property (sleep_i [*2]);
endmodule
`default_nettype wire

/* testbench/smbus_host_model.sv */
// Host side model issuing byte register cycles.
// Assumes the bank takes a request at the rising edge its strobe is high.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
	// Clock and read data
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	// Request lines
	output logic [7:0] addr_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic [7:0] wdata_o = 8'h00,
	output logic rd_o = 1'b0,
	output logic start_o = 1'b0
);
	// Idle lines show the inverse of the last value, never a stale match.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
	task automatic snap(output logic [31:0] t);
		@(posedge clk_sys_i);
		start_o <= 1'b1;
		@(posedge clk_sys_i);
		start_o <= 1'b0;
		for (int i = 0; i < 4; i++) rd(8'h1A + 8'(i), t[31-8*i -: 8]);
	endtask
	task automatic quota_clear(input logic [7:0] cfg);
		wr(8'h22, cfg | 8'h40);
		wr(8'h22, cfg);
	endtask
	task automatic beh_wr(input logic [5:0] b);
		logic [7:0] old;
		rd(8'h23, old);
		wr(8'h23, {b, old[1:0]});
	endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the quota register bank.
// Assumes a short update period so each tick comes every eight cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import quota_regs_pkg::*;
;
	logic clk_sys_i = 1'b0, srst_i = 1'b1, active_i = 1'b0, sleep_i = 1'b0;
	logic auto_drain_enable_i = 1'b0, other_alert_p1_i = 1'b0, other_alert_p2_i = 1'b0;
	logic [15:0] charge_delta_p1_i = 16'h0000, charge_delta_p2_i = 16'h0000, lf = 16'h0023;
	wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	wire logic reg_wr_i, reg_rd_i, reg_rd_start_i, manual_drain_load_p2_o;
	wire logic [1:0] min_bus_volt_sel_p2_o;
	wire logic [2:0] min_bus_current_sel_p2_o;
	quota_status_t quota_status_p1_o, quota_status_p2_o;
	int n_fail = 0, samples_checked = 0, tot, k;
	logic [7:0] mdl[int], v, cfg;
	logic [31:0] t;
	always #12.5 clk_sys_i = ~clk_sys_i;
	quota_reg_bank #(.DELTA_W(16), .UPDATE_COUNT(8)) DUT (.clk_sys_i, .srst_i, .reg_addr_i,
		.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rd_start_i, .reg_rdata_o, .active_i, .sleep_i,
		.charge_delta_p1_i, .charge_delta_p2_i, .other_alert_p1_i, .other_alert_p2_i,
		.auto_drain_enable_i, .quota_status_p1_o, .quota_status_p2_o, .manual_drain_load_p2_o,
		.min_bus_volt_sel_p2_o, .min_bus_current_sel_p2_o);
	smbus_host_model host (.clk_sys_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .start_o(reg_rd_start_i));
	function automatic logic [7:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdc(logic [7:0] a, logic [7:0] e);
		host.rd(a, v);
		chk("register", {24'h0, e}, {24'h0, v});
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		#(25 * 20000);
		n_fail++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		for (int a = 8'h1E; a < 8'h22; a++) mdl[a] = 8'hFF;
		mdl[8'h22] = 8'h11;
		mdl[8'h23] = 8'h96;
		foreach (mdl[a]) rdc(a[7:0], mdl[a]);
		host.wr(ADDR_TOTAL_P1, 8'hFF);
		rdc(8'h40, 8'h00);
		host.snap(t);
		chk("total", 32'h0, t);
		for (int a = 8'h1E; a < 8'h22; a++) begin
			mdl[a] = rnd();
			host.wr(a[7:0], mdl[a]);
			rdc(a[7:0], mdl[a]);
		end
		$display("test registers done");
		host.wr(ADDR_LIMIT_P1, 8'h00);
		host.wr(8'h21, 8'h03);
		for (int m = 0; m < 4; m++) begin
			charge_delta_p1_i <= {8'h01, rnd()};
			charge_delta_p2_i <= {8'h00, rnd()};
			cfg = {2'b10, 2'(m), 4'h1};
			host.quota_clear(cfg);
			active_i <= 1'b1;
			for (k = 0; k < 400 && quota_status_p1_o.hit_flag !== 1'b1; k++) @(posedge clk_sys_i);
			active_i <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
			host.snap(t);
			tot = int'(t[31:6]);
			chk("hit", 1, tot >= (3 << LIMIT_SHIFT) && tot - charge_delta_p1_i < (3 << LIMIT_SHIFT));
			chk("step", 0, tot % charge_delta_p1_i);
			chk("status", {1'b1, m < 2, m == 1 || m == 2, m == 2, m > 1}, quota_status_p1_o);
			// Another alert cause must keep the alert held after the quota clears.
			other_alert_p1_i <= m[1];
			if (m[0]) host.wr(ADDR_QUOTA_CFG, cfg & 8'h7F);
			else host.quota_clear(cfg);
			repeat (3) @(posedge clk_sys_i);
			chk("cleared", {31'h0, !m[1]}, quota_status_p1_o);
			other_alert_p1_i <= 1'b0;
			host.snap(t);
			chk("zeroed", 32'h0, t);
		end
		$display("test quota done");
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			auto_drain_enable_i <= i[0];
			host.beh_wr({i[1:0], v[0], i[2:0]});
			repeat (3) @(posedge clk_sys_i);
			chk("volt", i[1:0], min_bus_volt_sel_p2_o);
			chk("current", i[2:0], min_bus_current_sel_p2_o);
			chk("drain", v[0] & !i[0], manual_drain_load_p2_o);
			rdc(8'h23, {i[1:0], v[0], i[2:0], 2'b10});
		end
		sleep_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		chk("sleep", 5'h15, {min_bus_volt_sel_p2_o, min_bus_current_sel_p2_o});
		sleep_i <= 1'b0;
		rdc(8'h23, 8'h96);
		$display("test behaviour done");
		complete_run;
	end
endmodule
bind quota_reg_bank quota_reg_bank_asserts chk (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wr_i,
	.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .sleep_i, .auto_drain_enable_i, .other_alert_p1_i,
	.quota_status_p1_o, .manual_drain_load_p2_o, .min_bus_volt_sel_p2_o, .min_bus_current_sel_p2_o);
`default_nettype wire
